// File: pkg/fp_unit_pkg.sv
// constants, register map and encodings for the float scale/convert/round unit
package fp_unit_pkg;

  // ----------------------------------------------------------------
  // word format (bit 35 is the sign, 34:27 exponent, 26:0 fraction)
  // ----------------------------------------------------------------
  localparam int WORD_W = 36;
  localparam int FRAC_W = 27;
  localparam int SIGN_POS = 35;
  localparam int EXP_HI = 34;
  localparam int EXP_LO = 27;
  localparam int EXP_W = 11; // working exponent, signed
  localparam int EA_W = 18;
  localparam logic [7:0] EXP_BIAS_FLIP = 8'h80; // excess-128 as xor of top bit
  localparam logic signed [10:0] EXP_BIAS = 11'sd128;
  localparam logic signed [10:0] EXP_MAX = 11'sd127;
  localparam logic signed [10:0] EXP_MIN = -11'sd128;
  localparam logic signed [10:0] FIX_LIMIT = 11'sd35;
  localparam logic signed [10:0] FIX_POINT = 11'sd27;
  localparam logic signed [10:0] FLOAT_EXP = 11'sd35;
  localparam int FLOAT_SHIFT = 8;
  localparam int EA_SCALE_SIGN = 17; // bit 18 of the address result
  localparam int EA_SCALE_MAG_HI = 7; // bits 28-35 of the address result

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_AC_LO = 6'h00;
  localparam logic [5:0] OFS_AC_HI = 6'h04;
  localparam logic [5:0] OFS_MEM_LO = 6'h08;
  localparam logic [5:0] OFS_MEM_HI = 6'h0c;
  localparam logic [5:0] OFS_EA = 6'h10;
  localparam logic [5:0] OFS_LOW = 6'h14;
  localparam logic [5:0] OFS_CMD = 6'h18;
  localparam logic [5:0] OFS_FLAGS = 6'h1c;
  localparam logic [5:0] OFS_STATUS = 6'h20;

  // ----------------------------------------------------------------
  // command fields, operations and modes
  // ----------------------------------------------------------------
  localparam int CMD_OP_LO = 0;
  localparam int CMD_MODE_LO = 3;
  localparam int CMD_INTR_POS = 5;
  localparam logic [2:0] OP_SCALE = 3'h0; // exponent_scale_op
  localparam logic [2:0] OP_FIX_TRUNC = 3'h1;
  localparam logic [2:0] OP_FIX_ROUND = 3'h2;
  localparam logic [2:0] OP_FLOAT_ROUND = 3'h3; // int_to_float_rounding_op
  localparam logic [2:0] OP_NORM_ROUND = 3'h4;
  localparam logic [1:0] MODE_BASIC = 2'h0;
  localparam logic [1:0] MODE_IMMED = 2'h1;
  localparam logic [1:0] MODE_MEMORY = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // flag and status bit positions, reset values
  // ----------------------------------------------------------------
  localparam int FLG_OVF = 0;
  localparam int FLG_FOV = 1;
  localparam int FLG_FUND = 2;
  localparam int FLG_TRAP1 = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_AC_WR = 1;
  localparam int ST_MEM_WR = 2;
  localparam int ST_SKIP = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [35:0] WORD_RESET = 36'h0_0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_type;

endpackage : fp_unit_pkg

// File: hw/fp_normalizer.sv
// normalize a double-length magnitude fraction and optionally round it
module fp_normalizer import fp_unit_pkg::*; #(
  parameter int FW = 27
) (
  input wire logic signed [10:0] exp_in,
  input wire logic [2*FW-1:0] frac_in,
  input wire logic round_en,
  output logic signed [10:0] exp_out,
  output logic [FW-1:0] frac_out,
  output logic zero
);

  // ----------------------------------------------------------------
  // leading one search, left shift, round away from zero
  // ----------------------------------------------------------------
  logic [5:0] lead; // position of leading one
  logic [2*FW-1:0] shifted; // normalized double length
  logic [FW:0] rounded; // one carry bit spare

  always_comb begin
    lead = 6'h00;
    for (int i = 0; i < 2*FW; i++) begin
      if (frac_in[i]) begin
        lead = 6'(i);
      end
    end
    // vacated right bits take whatever low part the caller supplied
    shifted = frac_in << (6'(2*FW-1) - lead);
    exp_out = exp_in - 11'(6'(2*FW-1) - lead);
    rounded = {1'b0, shifted[2*FW-1:FW]};
    if (round_en && shifted[FW-1]) begin
      // dropped part is at least half an lsb
      rounded = rounded + {{FW{1'b0}}, 1'b1};
    end
    frac_out = rounded[FW-1:0];
    if (rounded[FW]) begin
      // carry out: renormalize one step right
      frac_out = rounded[FW:1];
      exp_out = exp_out + 11'sd1;
    end
    zero = (frac_in == '0);
  end

endmodule : fp_normalizer

// File: hw/fp_scale_convert.sv
// scale, fix, float and rounded-normalize datapath behind an avalon-mm slave
//
// How it works
// - scale factor is address bit 18 plus 28-35
// - factor -256..255 added to exponent
// - scale clears zero fraction, else normalizes, writes
// - exponent above 127 flags overflow, wraps down
// - exponent below -128 flags underflow too, wraps up
// - fix with exponent over 35 traps, no writes
// - fix shifts fraction by exponent minus 27
// - left shift zero-fills, right shift sign-fills
// - truncating fix drops fraction toward zero
// - rounding fix: half up positive, over half negative
// - float shifts right eight, exponent 35, normalizes
// - float rounds on next bit when few shifts
// - float and normalize rounding is away from zero
// - basic, immediate, memory, both operand modes
// - immediate operand is address half, zeros right
// - no prior alignment brings zeros in
// - interrupt-served instruction sets no flags
// - conversions read memory, write accumulator only
// - flags never cleared by hardware itself
module fp_scale_convert import fp_unit_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  state_type state; // idle or executing
  logic [35:0] ac; // accumulator word
  logic [35:0] mem; // memory operand word
  logic [17:0] ea; // effective address result
  logic [26:0] low; // low order fraction part
  logic [2:0] op; // latched operation
  logic [1:0] mode; // latched operand mode
  logic intr; // executed as interrupt instruction
  logic [3:0] flags; // sticky arithmetic flags
  logic [3:0] status; // last outcome
  logic rd_pend; // read data already registered
  logic wr_take; // write accepted this edge
  logic [31:0] wr_merged; // write data merged by lanes

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // while busy every access stalls, so register writes never race the datapath
  assign waitrequest = (state == ST_EXEC) ? (read | write) : (read & ~rd_pend);
  assign wr_take = write & ~waitrequest;

  // byte lanes merge into the current value of the addressed register
  always_comb begin
    wr_merged = readmux(address);
    for (int b = 0; b < 4; b++) begin
      if (byteenable[b]) begin
        wr_merged[8*b +: 8] = writedata[8*b +: 8];
      end
    end
  end

  // read mux, unmapped offsets read zero
  function automatic logic [31:0] readmux(input logic [5:0] a);
    case (a)
      OFS_AC_LO: readmux = ac[31:0];
      OFS_AC_HI: readmux = {28'h0, ac[35:32]};
      OFS_MEM_LO: readmux = mem[31:0];
      OFS_MEM_HI: readmux = {28'h0, mem[35:32]};
      OFS_EA: readmux = {14'h0, ea};
      OFS_LOW: readmux = {5'h0, low};
      OFS_CMD: readmux = {26'h0, intr, mode, op};
      OFS_FLAGS: readmux = {28'h0, flags};
      OFS_STATUS: readmux = {28'h0, status};
      default: readmux = 32'h0;
    endcase
  endfunction : readmux

  // reads take two cycles: capture, then answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pend <= 1'b0;
      readdata <= 32'h0;
    end else if (read && state == ST_IDLE && !rd_pend) begin
      rd_pend <= 1'b1;
      readdata <= readmux(address);
    end else begin
      rd_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // operand decode
  // ----------------------------------------------------------------
  logic [35:0] opnd; // selected non-accumulator operand
  logic [35:0] ac_mag; // accumulator magnitude
  logic [35:0] op_mag; // operand magnitude
  logic signed [10:0] ac_exp; // accumulator true exponent
  logic signed [10:0] op_exp; // operand true exponent
  logic signed [10:0] scale; // scale factor

  always_comb begin
    opnd = (mode == MODE_IMMED && op == OP_NORM_ROUND) ? {ea, 18'h0} : mem;
    ac_mag = ac[SIGN_POS] ? (~ac + 36'h1) : ac;
    op_mag = opnd[SIGN_POS] ? (~opnd + 36'h1) : opnd;
    ac_exp = $signed({3'h0, ac_mag[EXP_HI:EXP_LO]}) - EXP_BIAS;
    op_exp = $signed({3'h0, op_mag[EXP_HI:EXP_LO]}) - EXP_BIAS;
    // sign from bit 18, magnitude from bits 28-35, two's complement
    scale = $signed({{2{ea[EA_SCALE_SIGN]}}, ea[EA_SCALE_SIGN], ea[EA_SCALE_MAG_HI:0]});
  end

  // ----------------------------------------------------------------
  // shared normalizer input selection
  // ----------------------------------------------------------------
  logic signed [10:0] nrm_exp_in;
  logic [53:0] nrm_frac_in;
  logic nrm_round;
  logic signed [10:0] nrm_exp;
  logic [26:0] nrm_frac;
  logic nrm_zero;

  always_comb begin
    nrm_exp_in = ac_exp + scale;
    nrm_frac_in = {ac_mag[FRAC_W-1:0], 27'h0};
    nrm_round = 1'b0;
    case (op)
      OP_FLOAT_ROUND: begin
        // magnitude right eight, low bits follow so they come back first
        nrm_exp_in = FLOAT_EXP;
        nrm_frac_in = {op_mag[34:0], 19'h0};
        nrm_round = 1'b1;
      end
      OP_NORM_ROUND: begin
        // with no alignment beforehand the low part is zero and zeros come in
        nrm_exp_in = op_exp;
        nrm_frac_in = {op_mag[FRAC_W-1:0], low};
        nrm_round = 1'b1;
      end
      default: begin
      end
    endcase
  end

  fp_normalizer #(.FW(FRAC_W)) u_norm (
    .exp_in(nrm_exp_in),
    .frac_in(nrm_frac_in),
    .round_en(nrm_round),
    .exp_out(nrm_exp),
    .frac_out(nrm_frac),
    .zero(nrm_zero)
  );

  // pack sign, exponent and magnitude fraction, wrapping modulo 256
  function automatic logic [35:0] pack(input logic s, input logic signed [10:0] e, input logic [26:0] f);
    logic [35:0] w;
    w = {1'b0, e[7:0] ^ EXP_BIAS_FLIP, f};
    pack = s ? (~w + 36'h1) : w;
  endfunction : pack

  // ----------------------------------------------------------------
  // float to integer
  // ----------------------------------------------------------------
  logic signed [10:0] fix_n; // shift count
  logic [62:0] fix_ext; // fraction with room below the point
  logic [35:0] fix_int; // integral magnitude
  logic fix_half; // discarded part is at least a half
  logic fix_more; // discarded part beyond the half bit
  logic [35:0] fix_word; // signed result

  always_comb begin
    fix_n = op_exp - FIX_POINT;
    fix_ext = 63'h0;
    fix_int = 36'h0;
    fix_half = 1'b0;
    fix_more = 1'b0;
    if (fix_n >= 0) begin
      // left shift, zeros enter at the bottom
      fix_int = {9'h0, op_mag[26:0]} << fix_n[3:0];
    end else if (fix_n > -11'sd63) begin
      // right shift of the magnitude; sign fill is applied below
      fix_ext = {op_mag[26:0], 36'h0} >> 6'(-fix_n);
      fix_int = {9'h0, fix_ext[62:36]};
      fix_half = fix_ext[35];
      fix_more = |fix_ext[34:0];
    end
    // truncation of the magnitude equals adding one to a negative shifted word
    if (op == OP_FIX_ROUND) begin
      if (opnd[SIGN_POS] ? (fix_half && fix_more) : fix_half) begin
        fix_int = fix_int + 36'h1;
      end
    end
    fix_word = opnd[SIGN_POS] ? (~fix_int + 36'h1) : fix_int;
  end

  // ----------------------------------------------------------------
  // result, destinations and flag events
  // ----------------------------------------------------------------
  logic [35:0] res; // word to store
  logic to_ac; // accumulator receives res
  logic to_mem; // memory receives res
  logic skip; // instruction abandoned
  logic exp_hi; // final exponent above 127
  logic exp_lo; // final exponent below -128
  logic [3:0] flag_set; // flags raised this cycle
  logic [3:0] flag_clr; // flags cleared by software
  logic is_fix; // either conversion to integer

  always_comb begin
    is_fix = (op == OP_FIX_TRUNC) || (op == OP_FIX_ROUND);
    res = pack(op == OP_SCALE ? ac[SIGN_POS] : opnd[SIGN_POS], nrm_exp, nrm_frac);
    exp_hi = !nrm_zero && (nrm_exp > EXP_MAX);
    exp_lo = !nrm_zero && (nrm_exp < EXP_MIN);
    to_ac = 1'b1;
    to_mem = 1'b0;
    skip = 1'b0;
    if (nrm_zero) begin
      res = WORD_RESET;
    end
    if (is_fix) begin
      exp_hi = 1'b0;
      exp_lo = 1'b0;
      res = fix_word;
      skip = (op_exp > FIX_LIMIT);
      to_ac = !skip;
    end else if (op == OP_NORM_ROUND) begin
      to_ac = (mode != MODE_MEMORY);
      to_mem = (mode == MODE_MEMORY) || (mode == MODE_BOTH);
    end
    flag_set = 4'h0;
    if (state == ST_EXEC && !intr) begin
      flag_set[FLG_OVF] = exp_hi | exp_lo | skip;
      flag_set[FLG_FOV] = exp_hi | exp_lo;
      flag_set[FLG_FUND] = exp_lo;
      flag_set[FLG_TRAP1] = exp_hi | exp_lo | skip;
    end
    flag_clr = 4'h0;
    if (wr_take && address == OFS_FLAGS) begin
      flag_clr = writedata[3:0] & {4{byteenable[0]}};
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // a command write starts one execute cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_take && address == OFS_CMD) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // command register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op <= OP_SCALE;
      mode <= MODE_BASIC;
      intr <= 1'b0;
    end else if (wr_take && address == OFS_CMD) begin
      op <= wr_merged[CMD_OP_LO +: 3];
      mode <= wr_merged[CMD_MODE_LO +: 2];
      intr <= wr_merged[CMD_INTR_POS];
    end
  end

  // accumulator: software load or result write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ac <= WORD_RESET;
    end else if (state == ST_EXEC) begin
      if (to_ac) begin
        ac <= res;
      end
    end else if (wr_take && address == OFS_AC_LO) begin
      ac[31:0] <= wr_merged;
    end else if (wr_take && address == OFS_AC_HI) begin
      ac[35:32] <= wr_merged[3:0];
    end
  end

  // memory word: software load or memory-mode or both-mode result
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem <= WORD_RESET;
    end else if (state == ST_EXEC) begin
      if (to_mem) begin
        mem <= res;
      end
    end else if (wr_take && address == OFS_MEM_LO) begin
      mem[31:0] <= wr_merged;
    end else if (wr_take && address == OFS_MEM_HI) begin
      mem[35:32] <= wr_merged[3:0];
    end
  end

  // address result and low order part
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ea <= 18'h0;
      low <= 27'h0;
    end else if (wr_take && address == OFS_EA) begin
      ea <= wr_merged[17:0];
    end else if (wr_take && address == OFS_LOW) begin
      low <= wr_merged[26:0];
    end
  end

  // sticky flags: only software clears, and a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // outcome of the last instruction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= 4'h0;
    end else begin
      status[ST_BUSY] <= (state == ST_IDLE) && wr_take && (address == OFS_CMD);
      if (state == ST_EXEC) begin
        status[ST_AC_WR] <= to_ac;
        status[ST_MEM_WR] <= to_mem;
        status[ST_SKIP] <= skip;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_EXEC_ONE_CYCLE: assert property (state == ST_EXEC |=> state == ST_IDLE)
    else $error("execute lasted more than one cycle");
  AST_SCALE_ZERO_CLEAR: assert property (
    state == ST_EXEC && op == OP_SCALE && ac[26:0] == 27'h0 |=> ac == 36'h0)
    else $error("scale of zero fraction did not clear accumulator");
  AST_FIX_SKIP_KEEPS: assert property (
    state == ST_EXEC && is_fix && op_exp > FIX_LIMIT |=> ac == $past(ac) && mem == $past(mem))
    else $error("fix overflow changed accumulator or memory");
  AST_FIX_TRAP: assert property (
    state == ST_EXEC && is_fix && op_exp > FIX_LIMIT && !intr |=> flags[FLG_OVF] && flags[FLG_TRAP1])
    else $error("fix overflow did not raise overflow and trap");
  AST_EXP_HIGH: assert property (
    state == ST_EXEC && exp_hi && !intr |=> flags[FLG_OVF] && flags[FLG_FOV])
    else $error("exponent overflow not flagged");
  AST_EXP_LOW: assert property (
    state == ST_EXEC && exp_lo && !intr |=> flags[FLG_FUND] && flags[FLG_FOV])
    else $error("exponent underflow not flagged");
  AST_FLAGS_STICK: assert property (
    flags[FLG_OVF] && !(wr_take && address == OFS_FLAGS) |=> flags[FLG_OVF])
    else $error("overflow flag dropped without software clear");
  AST_INTR_NO_FLAGS: assert property (
    state == ST_EXEC && intr |=> flags == $past(flags))
    else $error("interrupt instruction changed flags");
  AST_CONVERT_MEM_SAFE: assert property (
    state == ST_EXEC && op != OP_NORM_ROUND |=> mem == $past(mem))
    else $error("conversion wrote memory");
  AST_MEMORY_MODE_AC: assert property (
    state == ST_EXEC && op == OP_NORM_ROUND && mode == MODE_MEMORY |=> ac == $past(ac) && status[ST_MEM_WR])
    else $error("memory mode touched accumulator");
  AST_READ_ANSWER: assert property (
    read && state == ST_IDLE && !rd_pend |-> waitrequest ##1 (rd_pend && !waitrequest))
    else $error("read answer not given in second cycle");

  COV_SCALE: cover property (state == ST_EXEC && op == OP_SCALE && !nrm_zero);
  COV_FIX_TRAP: cover property (state == ST_EXEC && is_fix && skip);
  COV_FLOAT_ROUND: cover property (state == ST_EXEC && op == OP_FLOAT_ROUND);
  COV_UNDERFLOW: cover property (state == ST_EXEC && exp_lo);

endmodule : fp_scale_convert

// File: dv/fp_seq_model.sv
// sequencer-side avalon-mm master model for the unit's register bus
module fp_seq_model (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // idle bus at time zero
  // ----------------------------------------
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
  end

  // one access; the request is held until waitrequest is seen low at an edge
  task automatic access(input logic [5:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // released data is scrambled so nothing relies on stale lanes
    writedata <= ~d;
  endtask : access
endmodule : fp_seq_model

// File: dv/float_scale_convert_round_unit_test.sv
// self-checking bench for the float scale, convert and round unit
module float_scale_convert_round_unit_test import fp_unit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // clock, reset, bus wires
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic [31:0] q; // scratch read word
  logic [35:0] w; // scratch 36-bit word
  logic [31:0] seed = 32'h23;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  localparam logic [3:0] F_OV = (4'h1 << FLG_OVF) | (4'h1 << FLG_FOV) | (4'h1 << FLG_TRAP1);
  localparam logic [3:0] F_UN = F_OV | (4'h1 << FLG_FUND);
  localparam logic [3:0] F_TR = (4'h1 << FLG_OVF) | (4'h1 << FLG_TRAP1);

  always #5 clk = ~clk;

  fp_scale_convert uut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
  fp_seq_model m (.clk(clk), .waitrequest(waitrequest), .readdata(readdata), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));

  // ----------------------------------------
  // helpers and expected-value functions
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // float word; negatives are the whole word negated
  function automatic logic [35:0] mk(input logic neg, input int e, input logic [26:0] f);
    logic [35:0] t;
    t = {1'b0, 8'(e + 128), f};
    return neg ? -t : t;
  endfunction : mk

  // scale factor: sign in ea[17], low byte of the two's complement in ea[7:0]
  function automatic logic [17:0] ea_of(input int e);
    logic [17:0] r;
    r = 18'h0;
    r[17] = e < 0;
    r[7:0] = 8'(e);
    return r;
  endfunction : ea_of

  // integer from a float; rounding done on the magnitude
  function automatic logic [35:0] fix_exp(input logic neg, input int e, input logic [26:0] f, input logic rnd_on);
    logic [35:0] t;
    t = {9'h0, f};
    if (e >= 27) t = t << (e - 27);
    else if (rnd_on) t = (t + (36'h1 << (26 - e)) - 36'(neg)) >> (27 - e);
    else t = t >> (27 - e);
    return neg ? -t : t;
  endfunction : fix_exp

  // float of a magnitude below 2^27, always exact
  function automatic logic [35:0] flt_exp(input logic neg, input logic [35:0] n);
    int p;
    p = 0;
    for (int b = 0; b < 36; b++) if (n[b]) p = b;
    return mk(neg, p + 1, 27'(n << (26 - p)));
  endfunction : flt_exp

  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] t;
    m.access(a, 1'b1, d, t);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    m.access(a, 1'b0, 32'h0, d);
  endtask : rd

  // a 36-bit word travels as lo then hi halves
  task automatic wr36(input logic [5:0] a, input logic [35:0] d);
    wr(a, d[31:0]);
    wr(a + 6'h4, {28'h0, d[35:32]});
  endtask : wr36

  task automatic rd36(input logic [5:0] a, output logic [35:0] d);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(a, lo);
    rd(a + 6'h4, hi);
    d = {hi[3:0], lo};
  endtask : rd36

  task automatic scl(input logic [35:0] ac, input int e, input logic intr);
    wr36(OFS_AC_LO, ac);
    wr(OFS_EA, {14'h0, ea_of(e)});
    wr(OFS_CMD, {26'h0, intr, MODE_BASIC, OP_SCALE});
    rd36(OFS_AC_LO, w);
  endtask : scl

  // boundary scale: flags cleared first, result and flags compared
  task automatic scale_case(input int a, input int e, input logic intr, input int s, input logic [3:0] f);
    wr(OFS_FLAGS, 32'hf);
    scl(mk(1'b0, a, 27'h4000000), e, intr);
    chk("scale_wrap", w, mk(1'b0, s, 27'h4000000));
    rd(OFS_FLAGS, q);
    chk("scale_flags", {32'h0, q[3:0]}, {32'h0, f});
  endtask : scale_case

  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      final_report();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic neg;
    int e;
    logic [26:0] fr;
    logic [35:0] n;
    logic [35:0] r;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_FLAGS, q);
    chk("flags_rst", {4'h0, q}, {32'h0, FLAGS_RESET});
    rd(6'h24, q);
    chk("unmapped", {4'h0, q}, 36'h0);
    // factor limits, exact limits, interrupt-served case, then sticky flags
    scale_case(0, 255, 1'b0, -1, F_OV);
    scale_case(0, -256, 1'b0, 0, F_UN);
    scale_case(0, 127, 1'b0, 127, 4'h0);
    scale_case(0, -128, 1'b0, -128, 4'h0);
    scale_case(100, 100, 1'b1, -56, 4'h0);
    scale_case(-100, -100, 1'b0, 56, F_UN);
    scl(mk(1'b0, 16, 27'h0), 5, 1'b0);
    chk("scale_zero", w, 36'h0);
    scl(mk(1'b0, 0, 27'h1000000), 0, 1'b0);
    chk("scale_norm", w, mk(1'b0, -2, 27'h4000000));
    for (int i = 0; i < 12; i++) begin
      e = int'(rnd() % 41) - 20;
      scl(mk(i[0], 3, 27'h4800000), e, 1'b0);
      chk("scale", w, mk(i[0], 3 + e, 27'h4800000));
    end
    rd(OFS_FLAGS, q);
    chk("sticky", {32'h0, q[3:0]}, {32'h0, F_UN});
    // float to integer, both kinds; second pass is an exact half, negative
    for (int i = 0; i < 20; i++) begin
      neg = i[0];
      e = (i == 1) ? 3 : 1 + int'(rnd() % 35);
      fr = (i == 1) ? 27'h5800000 : 27'(rnd()) | 27'h4000000;
      wr36(OFS_MEM_LO, mk(neg, e, fr));
      wr(OFS_CMD, {26'h0, 1'b0, MODE_BASIC, OP_FIX_TRUNC});
      rd36(OFS_AC_LO, w);
      chk("fix_trunc", w, fix_exp(neg, e, fr, 1'b0));
      wr(OFS_CMD, {26'h0, 1'b0, MODE_BASIC, OP_FIX_ROUND});
      rd36(OFS_AC_LO, w);
      chk("fix_round", w, fix_exp(neg, e, fr, 1'b1));
      rd36(OFS_MEM_LO, w);
      chk("fix_mem", w, mk(neg, e, fr));
    end
    // exponent too big: trap, nothing written
    wr(OFS_FLAGS, 32'hf);
    wr36(OFS_AC_LO, 36'h1_2345_6789);
    wr36(OFS_MEM_LO, mk(1'b0, 36, 27'h4000000));
    wr(OFS_CMD, {26'h0, 1'b0, MODE_BASIC, OP_FIX_ROUND});
    rd36(OFS_AC_LO, w);
    chk("trap_ac", w, 36'h1_2345_6789);
    rd(OFS_FLAGS, q);
    chk("trap_flags", {32'h0, q[3:0]}, {32'h0, F_TR});
    rd(OFS_STATUS, q);
    chk("trap_status", {32'h0, q[3:0]}, {32'h0, 4'h1 << ST_SKIP});
    rd36(OFS_MEM_LO, w);
    chk("trap_mem", w, mk(1'b0, 36, 27'h4000000));
    // integer to float, exact randoms then a rounding carry
    for (int i = 0; i < 10; i++) begin
      n = {9'h0, 27'(rnd()) | 27'h1};
      wr36(OFS_MEM_LO, i[0] ? -n : n);
      wr(OFS_CMD, {26'h0, 1'b0, MODE_BASIC, OP_FLOAT_ROUND});
      rd36(OFS_AC_LO, w);
      chk("float", w, flt_exp(i[0], n));
    end
    wr36(OFS_MEM_LO, 36'h0_3fff_ffff);
    wr(OFS_CMD, {26'h0, 1'b0, MODE_BASIC, OP_FLOAT_ROUND});
    rd36(OFS_AC_LO, w);
    chk("float_rnd", w, mk(1'b0, 31, 27'h4000000));
    // normalize-and-round over every mode, dropped part exactly half
    for (int i = 0; i < 4; i++) begin
      r = (i == MODE_IMMED) ? mk(1'b0, 1, 27'h4000001) : mk(1'b0, 0, 27'h4000001);
      wr36(OFS_AC_LO, 36'h0);
      wr36(OFS_MEM_LO, mk(1'b0, 0, 27'h4000000));
      wr(OFS_EA, 32'h10300);
      wr(OFS_LOW, 32'h4000000);
      wr(OFS_CMD, {26'h0, 1'b0, 2'(i), OP_NORM_ROUND});
      rd36(OFS_AC_LO, w);
      chk("mode_ac", w, (i == MODE_MEMORY) ? 36'h0 : r);
      rd36(OFS_MEM_LO, w);
      chk("mode_mem", w, (i >= MODE_MEMORY) ? r : mk(1'b0, 0, 27'h4000000));
    end
    // just below half rounds down; unnormalized with zero low part fills zeros
    wr(OFS_LOW, 32'h3ffffff);
    wr(OFS_CMD, {26'h0, 1'b0, MODE_BASIC, OP_NORM_ROUND});
    rd36(OFS_AC_LO, w);
    // the both-mode pass left the rounded word in memory, so that is the operand here
    chk("round_down", w, mk(1'b0, 0, 27'h4000001));
    wr36(OFS_MEM_LO, mk(1'b0, 0, 27'h1));
    wr(OFS_LOW, 32'h0);
    wr(OFS_CMD, {26'h0, 1'b0, MODE_BASIC, OP_NORM_ROUND});
    rd36(OFS_AC_LO, w);
    chk("zero_fill", w, mk(1'b0, -26, 27'h4000000));
    final_report();
  end
endmodule : float_scale_convert_round_unit_test
